// *** rss_top.v ***
// reset source sequencer: sequences the shared reset pin, clock gating
// and processor release, records the reset cause, holds the watchdog.
// assumes pclk is the crystal reference clock and the apb master is on
// pclk; supply comparators and the reset pin arrive asynchronously.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "rss_defines.vh"

module rss_top #(
  parameter WDOG_CYCLES = 262144,  // watchdog timeout in cycles
  parameter WDOG_W      = 20,      // watchdog counter width
  parameter EXT_MIN     = 4        // least pin low time, cycles (1..16)
) (
  input  wire        pclk,             // reference clock
  input  wire        presetn,          // power-on reset, active low
  input  wire        clk_en,           // freezes all state when low
  input  wire        psel,             // apb select
  input  wire        penable,          // apb enable
  input  wire        pwrite,           // apb direction
  input  wire [7:0]  paddr,            // apb byte address
  input  wire [31:0] pwdata,           // apb write data
  output reg  [31:0] prdata,           // apb read data
  output reg         pready,           // apb ready
  output reg         pslverr,          // apb error, unmapped address
  input  wire        supply_below_fall, // supply under falling trip
  input  wire        supply_below_rise, // supply under rising trip
  input  wire        bad_opcode,       // decoder saw unknown opcode
  input  wire        stop_exec,        // stop instruction executed
  input  wire        stop_enable,      // stop option bit
  input  wire        opcode_fetch,     // current fetch is an opcode
  input  wire        fetch_unmapped,   // fetch address is unmapped
  input  wire        monitor_entry,    // forced monitor mode entry
  input  wire        rst_pin_i,        // reset pin level
  output reg         rst_pin_o,        // reset pin drive value, low
  output reg         rst_pin_oe,       // reset pin drive enable
  output reg         cpu_reset,        // processor held in reset
  output reg         clocks_run,       // clocks to cpu and modules
  output reg         vector_start,     // pulse: fetch reset vector
  output reg         bus_clk_div4      // bus clock is ref / 4
);

  // one-hot sequencer states
  localparam [5:0] S_RUN  = 6'h01;
  localparam [5:0] S_LOWV = 6'h02;
  localparam [5:0] S_STAB = 6'h04;
  localparam [5:0] S_PINL = 6'h08;
  localparam [5:0] S_HOLD = 6'h10;
  localparam [5:0] S_EXT  = 6'h20;

  localparam [WDOG_W-1:0] WDOG_LAST = WDOG_CYCLES - 1;
  localparam [3:0]        EXT_LAST  = EXT_MIN - 1;

  // apb register selector
  function sel;
    input [7:0] a;
    input [7:0] off;
    begin
      sel = (a == off);
    end
  endfunction

  // last cycle of a count of n
  function last;
    input [12:0] c;
    input [12:0] n;
    begin
      last = (c == n - 13'h0001);
    end
  endfunction

  reg [5:0]        state_r;
  reg [5:0]        state_nxt;
  reg [12:0]       cnt_r;
  reg [12:0]       cnt_nxt;
  reg [7:0]        flags_r;
  reg [7:0]        flags_set;
  reg [WDOG_W-1:0] wdog_r;
  reg [3:0]        ext_cnt_r;
  reg              pin_s1_r;
  reg              pin_s2_r;
  reg              fall_s1_r;
  reg              fall_s2_r;
  reg              rise_s1_r;
  reg              rise_s2_r;

  wire acc      = psel & penable & pready;
  wire rd_cause = acc & ~pwrite & sel(paddr, `RSS_OFF_CAUSE);
  wire kick     = acc & pwrite & sel(paddr, `RSS_OFF_WDOG_KICK);
  wire mapped   = sel(paddr, `RSS_OFF_CAUSE) |
                  sel(paddr, `RSS_OFF_WDOG_KICK) |
                  sel(paddr, `RSS_OFF_STATE);

  // reset sources; a data fetch from an unmapped address is not one
  wire bad_opcode_flag     = bad_opcode | (stop_exec & ~stop_enable);
  wire bad_fetch_address_flag     = opcode_fetch & fetch_unmapped;
  wire wdog_ovf = (state_r == S_RUN) & (wdog_r == WDOG_LAST);
  wire ext_hit  = (ext_cnt_r == EXT_LAST) & ~pin_s2_r;

  // two-flop synchronisers; only the second stage is ever read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r  <= 1'b1;
      pin_s2_r  <= 1'b1;
      fall_s1_r <= 1'b0;
      fall_s2_r <= 1'b0;
      rise_s1_r <= 1'b0;
      rise_s2_r <= 1'b0;
    end else if (clk_en) begin
      pin_s1_r  <= rst_pin_i;
      pin_s2_r  <= pin_s1_r;
      fall_s1_r <= supply_below_fall;
      fall_s2_r <= fall_s1_r;
      rise_s1_r <= supply_below_rise;
      rise_s2_r <= rise_s1_r;
    end
  end

  // sequencer next state; a supply drop overrides every other phase
  always @* begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + 13'h0001;
    flags_set = 8'h00;
    case (state_r)
      S_RUN: begin
        cnt_nxt = 13'h0000;
        if (wdog_ovf | bad_opcode_flag | bad_fetch_address_flag | monitor_entry)
          state_nxt = S_PINL;
        else if (ext_hit) begin
          state_nxt = S_EXT;
          flags_set[`RSS_F_PIN] = 1'b1;
        end
        flags_set[`RSS_F_WDOG] = wdog_ovf;
        flags_set[`RSS_F_BAD_OPCODE_FLAG] = bad_opcode_flag;
        flags_set[`RSS_F_BAD_FETCH_ADDRESS_FLAG] = bad_fetch_address_flag;
        flags_set[`RSS_F_MON]  = monitor_entry;
      end
      S_LOWV: begin
        cnt_nxt = 13'h0000;
        if (!rise_s2_r)
          state_nxt = S_STAB;
      end
      S_STAB: begin
        if (last(cnt_r, `RSS_STAB_CYC)) begin
          state_nxt = S_PINL;
          cnt_nxt   = 13'h0000;
        end
      end
      S_PINL: begin
        if (last(cnt_r, `RSS_PIN_CYC)) begin
          state_nxt = S_HOLD;
          cnt_nxt   = 13'h0000;
        end
      end
      S_HOLD: begin
        if (last(cnt_r, `RSS_HOLD_CYC)) begin
          state_nxt = S_RUN;
          cnt_nxt   = 13'h0000;
          flags_set[`RSS_F_PIN] = ~pin_s2_r;
        end
      end
      S_EXT: begin
        cnt_nxt = 13'h0000;
        if (pin_s2_r)
          state_nxt = S_HOLD;
      end
      default: begin
        state_nxt = S_STAB;
        cnt_nxt   = 13'h0000;
      end
    endcase
    // supply at falling trip: hold pin low until it recovers
    if (fall_s2_r && state_r != S_LOWV) begin
      state_nxt = S_LOWV;
      cnt_nxt   = 13'h0000;
      flags_set[`RSS_F_LVI] = 1'b1;
    end
  end

  // sequencer state and registered outputs; power-on enters
  // stabilization directly with the pin already driven
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r      <= S_STAB;
      cnt_r        <= 13'h0000;
      rst_pin_o    <= 1'b0;
      rst_pin_oe   <= 1'b1;
      cpu_reset    <= 1'b1;
      clocks_run   <= 1'b0;
      vector_start <= 1'b0;
      bus_clk_div4 <= 1'b1;
    end else if (clk_en) begin
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      rst_pin_o    <= 1'b0;
      rst_pin_oe   <= |(state_nxt & (S_LOWV | S_STAB | S_PINL));
      cpu_reset    <= (state_nxt != S_RUN);
      clocks_run   <= ~|(state_nxt & (S_LOWV | S_STAB));
      vector_start <= (state_r == S_HOLD) & (state_nxt == S_RUN);
      // any reset phase forces the slow bus clock
      bus_clk_div4 <= (state_nxt != S_RUN);
    end
  end

  // external pin filter: low must persist before it counts as reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ext_cnt_r <= 4'h0;
    else if (clk_en) begin
      if (state_r != S_RUN || pin_s2_r)
        ext_cnt_r <= 4'h0;
      else if (ext_cnt_r != EXT_LAST)
        ext_cnt_r <= ext_cnt_r + 4'h1;
    end
  end

  // watchdog counter; cleared by a kick write or by any reset phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      wdog_r <= {WDOG_W{1'b0}};
    else if (clk_en) begin
      if (kick || state_r != S_RUN || wdog_ovf)
        wdog_r <= {WDOG_W{1'b0}};
      else
        wdog_r <= wdog_r + {{(WDOG_W-1){1'b0}}, 1'b1};
    end
  end

  // cause flags: a read clears only what it returned, so an event in
  // the same cycle as the read survives
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      flags_r <= `RSS_CAUSE_POR;
    else if (clk_en) begin
      if (rd_cause)
        flags_r <= (flags_r & ~prdata[7:0]) | flags_set;
      else
        flags_r <= flags_r | flags_set;
    end
  end

  // apb slave with one wait state; read data is captured when pready
  // rises and stands through the completing edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (clk_en) begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel && penable && !pready) begin
        if (!pwrite && sel(paddr, `RSS_OFF_CAUSE))
          prdata <= {24'h000000, flags_r};
        else if (!pwrite && sel(paddr, `RSS_OFF_STATE))
          prdata <= {26'h0000000, state_r};
        else
          prdata <= 32'h00000000;
      end
    end
  end

endmodule

// *** rss_defines.vh ***
// constants for the reset source sequencer: offsets, flag bits, counts
// assumes pclk is the crystal reference clock; included by rss_top.v
`ifndef RSS_DEFINES_VH
`define RSS_DEFINES_VH

// register byte offsets
`define RSS_OFF_CAUSE     8'h00
`define RSS_OFF_WDOG_KICK 8'h04
`define RSS_OFF_STATE     8'h08

// reset_cause_flags bit positions
`define RSS_F_POR   7
`define RSS_F_PIN   6
`define RSS_F_WDOG  5
`define RSS_F_BAD_OPCODE_FLAG  4
`define RSS_F_BAD_FETCH_ADDRESS_FLAG  3
`define RSS_F_MON   2
`define RSS_F_LVI   1

// cause register after power-on: power and supply flags set
`define RSS_CAUSE_POR 8'h82

// sequence counts in reference clock cycles
`define RSS_STAB_CYC 13'h1000
`define RSS_PIN_CYC  13'h0020
`define RSS_HOLD_CYC 13'h0020

`endif

// *** rss_line_model.sv ***
// open-drain reset line with pull-up, shared with outside devices
// assumes the bench moves hold_low just after pclk edges
`timescale 1ns/10ps
module rss_line_model (
  input  wire logic oe,       // design drives the line
  input  wire logic drv,      // design drive value
  input  wire logic hold_low, // outside device pulls low
  output wire logic level     // resolved line level
);
  // wired-and: any party pulling low beats the pull-up
  assign level = (oe ? drv : 1'b1) & ~hold_low;
endmodule

// *** rss_top_checker.sv ***
// assertions on rss_top ports: pin, hold, gating, sources, apb
// assumes pclk is the only clock and presetn its async reset
`timescale 1ns/10ps
module rss_top_checker (
  input wire logic       pclk,    // reference clock
  input wire logic       presetn, // reset, active low
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       bad_opcode,
  input wire logic       monitor_entry,
  input wire logic       rst_pin_oe,
  input wire logic       cpu_reset,
  input wire logic       clocks_run,
  input wire logic       vector_start,
  input wire logic       bus_clk_div4
);
  logic [12:0] low_r;  // cycles pin driven with clocks on
  logic [12:0] gate_r; // cycles with clocks gated
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // counts too long for a repetition operator
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_r <= 13'h0000;
      gate_r <= 13'h0000;
    end else begin
      low_r <= (rst_pin_oe && clocks_run) ? low_r + 13'h0001 : 13'h0000;
      gate_r <= clocks_run ? 13'h0000 : gate_r + 13'h0001;
    end
  end

  property p_pin; $fell(rst_pin_oe) |-> low_r == 13'h0020; endproperty
  a_pin: assert property (p_pin)
    else $error("pin drive length wrong");
  property p_hold; $fell(rst_pin_oe) |-> ##32 $fell(cpu_reset); endproperty
  a_hold: assert property (p_hold)
    else $error("hold after pin wrong");
  property p_vec; $fell(cpu_reset) |-> vector_start ##1 !vector_start;
  endproperty
  a_vec: assert property (p_vec)
    else $error("vector pulse wrong");
  property p_gate; !clocks_run |-> rst_pin_oe && cpu_reset; endproperty
  a_gate: assert property (p_gate)
    else $error("pin free while clocks gated");
  property p_stab; $rose(clocks_run) |-> gate_r >= 13'h0fff; endproperty
  a_stab: assert property (p_stab)
    else $error("stabilization too short");
  property p_src;
    (bad_opcode || monitor_entry) && !cpu_reset |=> rst_pin_oe && cpu_reset;
  endproperty
  a_src: assert property (p_src)
    else $error("source did not reset");
  property p_div4; cpu_reset |-> bus_clk_div4; endproperty
  a_div4: assert property (p_div4)
    else $error("bus clock not divided");
  property p_rdy; psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("apb ready timing wrong");
  c_rel: cover property ($fell(cpu_reset));
  c_src: cover property (bad_opcode && !cpu_reset);
  c_gate: cover property ($fell(clocks_run));
endmodule

bind rss_top rss_top_checker rss_top_checker_i (.pclk, .presetn, .psel,
  .penable, .pready, .bad_opcode, .monitor_entry, .rst_pin_oe,
  .cpu_reset, .clocks_run, .vector_start, .bus_clk_div4);

// *** rss_top_tb.sv ***
// self-checking bench for rss_top: source table, then awkward cases
// assumes rss_line_model stands for the outside reset devices
`timescale 1ns/10ps
module rss_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic        supply_below_fall, supply_below_rise, rd_err, ext_low;
  logic        rst_pin_o, rst_pin_oe, cpu_reset, clocks_run, pin_lvl;
  logic        vector_start, bus_clk_div4;
  logic [5:0]  src; // opcode, stop, stop on, fetch, unmapped, monitor
  int          err_count, tests_run, n, cyc;
  // source inputs beside the cause byte they leave
  logic [13:0] rows [6] = '{14'h2010, 14'h1010, 14'h1800, 14'h0608,
                            14'h0200, 14'h0104};

  rss_top #(.WDOG_CYCLES(64)) rss_top_i (.pclk, .presetn, .clk_en(1'b1),
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .supply_below_fall, .supply_below_rise, .bad_opcode(src[5]),
    .stop_exec(src[4]), .stop_enable(src[3]), .opcode_fetch(src[2]),
    .fetch_unmapped(src[1]), .monitor_entry(src[0]), .rst_pin_i(pin_lvl),
    .rst_pin_o, .rst_pin_oe, .cpu_reset, .clocks_run, .vector_start,
    .bus_clk_div4);
  rss_line_model rss_line_model_i (.oe(rst_pin_oe), .drv(rst_pin_o),
    .hold_low(ext_low), .level(pin_lvl));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // three full stabilizations dominate the run time
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop;
    end
  end

  task report_and_stop;
    if (err_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("mismatch %s exp %h got %h", nm, e, g);
      err_count++;
    end
  endtask
  // one apb transfer; the slave decides when it is done
  task apb(input logic w, input logic [7:0] a);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 20)
      err_count++;
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd_chk(input logic [7:0] e);
    apb(1'b0, 8'h00);
    chk("cause", {24'h000000, e}, rd_data);
  endtask
  // edges until the processor is let go, bounded
  task wait_vec;
    n = 0;
    while (vector_start !== 1'b1 && n < 6000) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task por;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("div4", 1, bus_clk_div4);
    presetn <= 1'b1;
    wait_vec;
    chk("por_time", 1, n > 4160 && n < 4164);
    rd_chk(8'h82);
    rd_chk(8'h00);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, src} = '0;
    {ext_low, supply_below_fall, supply_below_rise} = '0;
    pwdata = 32'h000000ff;
    por;
    apb(1'b1, 8'h00);
    rd_chk(8'h00);
    apb(1'b0, 8'h0c);
    chk("gap_err", 1, rd_err);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 8'h04);
      src <= rows[i][13:8];
      @(posedge pclk) src <= 6'h00;
      if (rows[i][7:0] != 8'h00) begin
        wait_vec;
        chk("src_time", 65, n);
      end else begin
        repeat (4) @(posedge pclk);
        chk("no_reset", 0, cpu_reset);
      end
      rd_chk(rows[i][7:0]);
    end
    // outside device keeps the line low past the pin sample
    src <= 6'h20;
    @(posedge pclk) src <= 6'h00;
    ext_low <= 1'b1;
    repeat (80) @(posedge pclk);
    ext_low <= 1'b0;
    wait_vec;
    rd_chk(8'h50);
    repeat (6) begin
      apb(1'b1, 8'h04);
      repeat (30) @(posedge pclk);
    end
    chk("kicked", 0, cpu_reset);
    wait_vec;
    rd_chk(8'h20);
    ext_low <= 1'b1;
    repeat (10) @(posedge pclk);
    ext_low <= 1'b0;
    wait_vec;
    por;
    {supply_below_fall, supply_below_rise} <= 2'b11;
    repeat (8) @(posedge pclk);
    chk("gated", 0, clocks_run);
    chk("pin_low", 1, rst_pin_oe);
    chk("pin_val", 0, rst_pin_o);
    apb(1'b0, 8'h08);
    chk("state", 32'h00000002, rd_data);
    chk("state_err", 0, rd_err);
    {supply_below_fall, supply_below_rise} <= 2'b00;
    wait_vec;
    chk("lv_time", 1, n > 4160 && n < 4168);
    rd_chk(8'h02);
    report_and_stop;
  end
endmodule
